// file: verilog/ppo_port_regs.vh
`ifndef PPO_PORT_REGS_VH
`define PPO_PORT_REGS_VH

// register indices; byte address on the bus is four times the index
`define PPO_IDX_W 6
`define PPO_IDX_E_LATCH 6'h03
`define PPO_IDX_CTRL 6'h04
`define PPO_IDX_D_PIN 6'h10
`define PPO_IDX_D_DIR 6'h11
`define PPO_IDX_D_LATCH 6'h12
`define PPO_IDX_C_PIN 6'h13
`define PPO_IDX_C_DIR 6'h14
`define PPO_IDX_C_LATCH 6'h15
`define PPO_IDX_B_PIN 6'h16
`define PPO_IDX_B_DIR 6'h17
`define PPO_IDX_B_LATCH 6'h18
`define PPO_IDX_A_PIN 6'h19
`define PPO_IDX_A_DIR 6'h1a
`define PPO_IDX_A_LATCH 6'h1b
// data-space alias bit: index plus 0x20 reaches the same register
`define PPO_ALIAS_BIT 5

// control register fields
`define PPO_CTRL_ASYNC_BIT 0
`define PPO_CTRL_EXTMEM_BIT 1
`define PPO_CTRL_COMPAT_BIT 2
`define PPO_CTRL_WMASK 8'h03

// reset values
`define PPO_LATCH_RST 8'h00
`define PPO_DIR_RST 8'h00
`define PPO_CTRL_RST 8'h00

// fifth port pin positions
`define PPO_G_XTAL_A 4
`define PPO_G_XTAL_B 3
`define PPO_G_ALE 2
`define PPO_G_RD 1
`define PPO_G_WR 0

`endif

// file: verilog/ppo_port_io.v
// How it works
// - in compatibility mode the fifth port only serves its alternate functions
// - async timer select detaches fifth-port bit 4 for the timer oscillator
// - async timer select detaches fifth-port bit 3 for the timer oscillator
// - crystal pins: pull-up, direction, input overrides active with value zero
// - ext memory: bits 2,1 pull-up off, output, driven by strobe, no input override
// - ext memory: bit 0 pull-up off, output, follows write strobe
// - bit 2 of the fifth port carries the address latch enable
// - bit 1 of the fifth port carries the read strobe
// - bit 0 of the fifth port carries the write strobe
// - first port data at 0x1b, direction at 0x1a, read-write, reset zero
// - first port pin sample at 0x19, read-only, follows the pins
// - second port data, direction, pin at 0x18, 0x17, 0x16
// - third port data, direction, pin at 0x15, 0x14, 0x13, reset zero
// - fourth port data, direction, pin at 0x12, 0x11, 0x10, pin read-only
// - fifth-listed port data register at 0x03, read-write, reset zero
// - compatibility mode makes the third port a push-pull output driving its data register, zero after reset
// - third port takes that state straight from reset
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`include "ppo_port_regs.vh"

module ppo_port_io (
    input wire mclk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire compat_mode,
    input wire [7:0] pad_a_in,
    output reg [7:0] pad_a_out,
    output reg [7:0] pad_a_oe,
    output reg [7:0] pad_a_pullup,
    input wire [7:0] pad_b_in,
    output reg [7:0] pad_b_out,
    output reg [7:0] pad_b_oe,
    output reg [7:0] pad_b_pullup,
    input wire [7:0] pad_c_in,
    output reg [7:0] pad_c_out,
    output reg [7:0] pad_c_oe,
    output reg [7:0] pad_c_pullup,
    input wire [7:0] pad_d_in,
    output reg [7:0] pad_d_out,
    output reg [7:0] pad_d_oe,
    output reg [7:0] pad_d_pullup,
    output reg [7:0] port_e_latch,
    input wire ext_ale,
    input wire ext_rd_strobe,
    input wire ext_wr_strobe,
    input wire [4:0] pad_g_in,
    output reg [4:0] pad_g_out,
    output reg [4:0] pad_g_oe,
    output reg [4:0] pad_g_pullup,
    output reg [4:0] pad_g_din,
    output reg [1:0] timer_crystal_link
);

    localparam NPIN = 37;
    localparam NG = 5;

    // bus decode; the alias bit is ignored so both windows hit one register
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [`PPO_IDX_W-1:0] idx_raw = wb_adr_i[7:2];
    wire [`PPO_IDX_W-1:0] idx = idx_raw & ~(6'h01 << `PPO_ALIAS_BIT);
    // a write lands on the edge that shows ack to the master and no earlier,
    // so a request withdrawn before its answer changes nothing
    wire wr_en = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    // one select per writable register; pin registers have none, so writes there vanish
    wire hit_a_latch = (idx == `PPO_IDX_A_LATCH);
    wire hit_a_dir = (idx == `PPO_IDX_A_DIR);
    wire hit_b_latch = (idx == `PPO_IDX_B_LATCH);
    wire hit_b_dir = (idx == `PPO_IDX_B_DIR);
    wire hit_c_latch = (idx == `PPO_IDX_C_LATCH);
    wire hit_c_dir = (idx == `PPO_IDX_C_DIR);
    wire hit_d_latch = (idx == `PPO_IDX_D_LATCH);
    wire hit_d_dir = (idx == `PPO_IDX_D_DIR);
    wire hit_e_latch = (idx == `PPO_IDX_E_LATCH);
    wire hit_ctrl = (idx == `PPO_IDX_CTRL);

    // software-visible registers and their next values
    reg [7:0] a_latch_q;
    reg [7:0] a_latch_d;
    reg [7:0] a_dir_q;
    reg [7:0] a_dir_d;
    reg [7:0] b_latch_q;
    reg [7:0] b_latch_d;
    reg [7:0] b_dir_q;
    reg [7:0] b_dir_d;
    reg [7:0] c_latch_q;
    reg [7:0] c_latch_d;
    reg [7:0] c_dir_q;
    reg [7:0] c_dir_d;
    reg [7:0] d_latch_q;
    reg [7:0] d_latch_d;
    reg [7:0] d_dir_q;
    reg [7:0] d_dir_d;
    reg [7:0] e_latch_q;
    reg [7:0] e_latch_d;
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;

    // pin synchronisers: three stages, a change counts once stages two and three agree
    reg [NPIN-1:0] sync1_q;
    reg [NPIN-1:0] sync2_q;
    reg [NPIN-1:0] sync3_q;
    reg [NPIN-1:0] pin_q;
    wire [NPIN-1:0] pins_raw = {pad_g_in, pad_d_in, pad_c_in, pad_b_in, pad_a_in};

    // no reset here: the pins are unknown anyway; only stage two reads stage one
    always @(posedge mclk) begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    // filtered pin image; zero in reset, live from the first edge after it, as the unreset stages keep sampling through reset
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_filt
            always @(posedge mclk) begin
                if (!resetn) begin
                    pin_q[gi] <= 1'h0;
                end else if (sync2_q[gi] == sync3_q[gi]) begin
                    pin_q[gi] <= sync3_q[gi];
                end
            end
        end
    endgenerate

    // next values: only the addressed register takes the bus byte, the rest hold;
    // pin registers and unmapped indices have no select, so their data is dropped
    always @* begin
        a_latch_d = a_latch_q;
        a_dir_d = a_dir_q;
        b_latch_d = b_latch_q;
        b_dir_d = b_dir_q;
        c_latch_d = c_latch_q;
        c_dir_d = c_dir_q;
        d_latch_d = d_latch_q;
        d_dir_d = d_dir_q;
        e_latch_d = e_latch_q;
        ctrl_d = ctrl_q;
        if (wr_en) begin
            if (hit_a_latch) begin
                a_latch_d = wb_dat_i[7:0];
            end
            if (hit_a_dir) begin
                a_dir_d = wb_dat_i[7:0];
            end
            if (hit_b_latch) begin
                b_latch_d = wb_dat_i[7:0];
            end
            if (hit_b_dir) begin
                b_dir_d = wb_dat_i[7:0];
            end
            if (hit_c_latch) begin
                c_latch_d = wb_dat_i[7:0];
            end
            if (hit_c_dir) begin
                c_dir_d = wb_dat_i[7:0];
            end
            if (hit_d_latch) begin
                d_latch_d = wb_dat_i[7:0];
            end
            if (hit_d_dir) begin
                d_dir_d = wb_dat_i[7:0];
            end
            if (hit_e_latch) begin
                e_latch_d = wb_dat_i[7:0];
            end
            if (hit_ctrl) begin
                ctrl_d = wb_dat_i[7:0] & `PPO_CTRL_WMASK;
            end
        end
    end

    // register bank; reset clears every data and direction byte
    always @(posedge mclk) begin
        if (!resetn) begin
            a_latch_q <= `PPO_LATCH_RST;
            a_dir_q <= `PPO_DIR_RST;
            b_latch_q <= `PPO_LATCH_RST;
            b_dir_q <= `PPO_DIR_RST;
            c_latch_q <= `PPO_LATCH_RST;
            c_dir_q <= `PPO_DIR_RST;
            d_latch_q <= `PPO_LATCH_RST;
            d_dir_q <= `PPO_DIR_RST;
            e_latch_q <= `PPO_LATCH_RST;
            ctrl_q <= `PPO_CTRL_RST;
        end else begin
            a_latch_q <= a_latch_d;
            a_dir_q <= a_dir_d;
            b_latch_q <= b_latch_d;
            b_dir_q <= b_dir_d;
            c_latch_q <= c_latch_d;
            c_dir_q <= c_dir_d;
            d_latch_q <= d_latch_d;
            d_dir_q <= d_dir_d;
            e_latch_q <= e_latch_d;
            ctrl_q <= ctrl_d;
        end
    end

    // read mux; bits above the byte read zero, unmapped reads give zero
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (idx)
            `PPO_IDX_A_LATCH: rd_byte = a_latch_q;
            `PPO_IDX_A_DIR: rd_byte = a_dir_q;
            `PPO_IDX_A_PIN: rd_byte = pin_q[7:0];
            `PPO_IDX_B_LATCH: rd_byte = b_latch_q;
            `PPO_IDX_B_DIR: rd_byte = b_dir_q;
            `PPO_IDX_B_PIN: rd_byte = pin_q[15:8];
            `PPO_IDX_C_LATCH: rd_byte = c_latch_q;
            `PPO_IDX_C_DIR: rd_byte = c_dir_q;
            `PPO_IDX_C_PIN: rd_byte = pin_q[23:16];
            `PPO_IDX_D_LATCH: rd_byte = d_latch_q;
            `PPO_IDX_D_DIR: rd_byte = d_dir_q;
            `PPO_IDX_D_PIN: rd_byte = pin_q[31:24];
            `PPO_IDX_E_LATCH: rd_byte = e_latch_q;
            `PPO_IDX_CTRL: rd_byte = ctrl_q | ({7'h00, compat_mode} << `PPO_CTRL_COMPAT_BIT);
            default: rd_byte = 8'h00;
        endcase
    end

    // classic slave: ack one cycle after the strobe, dropped the cycle after
    always @(posedge mclk) begin
        if (!resetn) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    // a pin that listens gets its pull-up from its latch bit; a driving pin never does
    wire [7:0] a_pullup_d = a_latch_q & ~a_dir_q;
    wire [7:0] b_pullup_d = b_latch_q & ~b_dir_q;
    // compatibility mode forces port c to drive, whatever its direction register holds
    wire [7:0] c_dir_eff = compat_mode ? 8'hff : c_dir_q;
    wire [7:0] c_pullup_d = c_latch_q & ~c_dir_eff;
    wire [7:0] d_pullup_d = d_latch_q & ~d_dir_q;

    // port a: direction one drives the latch, zero is an input
    always @(posedge mclk) begin
        if (!resetn) begin
            pad_a_out <= 8'h00;
            pad_a_oe <= 8'h00;
            pad_a_pullup <= 8'h00;
        end else begin
            pad_a_out <= a_latch_q;
            pad_a_oe <= a_dir_q;
            pad_a_pullup <= a_pullup_d;
        end
    end

    // port b, same shape as port a
    always @(posedge mclk) begin
        if (!resetn) begin
            pad_b_out <= 8'h00;
            pad_b_oe <= 8'h00;
            pad_b_pullup <= 8'h00;
        end else begin
            pad_b_out <= b_latch_q;
            pad_b_oe <= b_dir_q;
            pad_b_pullup <= b_pullup_d;
        end
    end

    // port c: the fuse is a level, so it sets the drive both in reset and on every later edge
    always @(posedge mclk) begin
        if (!resetn) begin
            pad_c_out <= 8'h00;
            pad_c_oe <= {8{compat_mode}};
            pad_c_pullup <= 8'h00;
        end else begin
            pad_c_out <= c_latch_q;
            pad_c_oe <= c_dir_eff;
            pad_c_pullup <= c_pullup_d;
        end
    end

    // port d, same shape as port a
    always @(posedge mclk) begin
        if (!resetn) begin
            pad_d_out <= 8'h00;
            pad_d_oe <= 8'h00;
            pad_d_pullup <= 8'h00;
        end else begin
            pad_d_out <= d_latch_q;
            pad_d_oe <= d_dir_q;
            pad_d_pullup <= d_pullup_d;
        end
    end

    // port e has no pads in this block; its latch is copied out for the pad ring
    always @(posedge mclk) begin
        if (!resetn) begin
            port_e_latch <= 8'h00;
        end else begin
            port_e_latch <= e_latch_q;
        end
    end

    // fifth port override pairs, bit order 4..0
    wire async_timer_clock_select = ctrl_q[`PPO_CTRL_ASYNC_BIT];
    wire ext_memory_enable = ctrl_q[`PPO_CTRL_EXTMEM_BIT];
    // the crystal pins answer to the timer select, the strobe pins to the memory enable
    wire [4:0] xtal_mask = {{2{async_timer_clock_select}}, 3'h0};
    wire [4:0] strobe_mask = {2'h0, {3{ext_memory_enable}}};
    // pull-up and direction: both groups force them, the strobes to output
    wire [4:0] pullup_override_enable = xtal_mask | strobe_mask;
    wire [4:0] pullup_override_value = 5'h00;
    wire [4:0] direction_override_enable = xtal_mask | strobe_mask;
    wire [4:0] direction_override_value = {2'h0, 3'h7};
    // output value: only the strobes; the oscillator owns the crystal pins
    wire [4:0] output_override_enable = strobe_mask;
    wire [4:0] output_override_value = {2'h0, ext_ale, ext_rd_strobe, ext_wr_strobe};
    // input gate: the crystal pins lose their digital input, the strobes keep theirs
    wire [4:0] input_gate_override_enable = xtal_mask;
    wire [4:0] input_gate_override_value = 5'h00;

    // no general register sits behind this port here, so the base is a bare input
    // without pull-up; compatibility mode also gates its digital input off
    wire [4:0] base_gate = {5{~compat_mode}};

    // one mux per pin and control; an active enable replaces the base control
    wire [4:0] g_pu;
    wire [4:0] g_dd;
    wire [4:0] g_pv;
    wire [4:0] g_gate;
    genvar gj;
    generate
        for (gj = 0; gj < NG; gj = gj + 1) begin : g_ovr
            assign g_pu[gj] = pullup_override_enable[gj] ?
                pullup_override_value[gj] : 1'h0;
            assign g_dd[gj] = direction_override_enable[gj] ?
                direction_override_value[gj] : 1'h0;
            assign g_pv[gj] = output_override_enable[gj] ?
                output_override_value[gj] : 1'h0;
            assign g_gate[gj] = input_gate_override_enable[gj] ?
                input_gate_override_value[gj] : base_gate[gj];
        end
    endgenerate

    // fifth port pads, registered like the rest so every output leaves a flip-flop
    always @(posedge mclk) begin
        if (!resetn) begin
            pad_g_out <= 5'h00;
            pad_g_oe <= 5'h00;
            pad_g_pullup <= 5'h00;
            pad_g_din <= 5'h00;
            timer_crystal_link <= 2'h0;
        end else begin
            pad_g_out <= g_pv;
            pad_g_oe <= g_dd;
            pad_g_pullup <= g_pu;
            pad_g_din <= pin_q[36:32] & g_gate;
            timer_crystal_link <= {2{async_timer_clock_select}};
        end
    end

endmodule // ppo_port_io

// file: verification/ppo_pin_model.sv
`timescale 1ns/1ns
module ppo_pin_model #(
    parameter W = 8
) (
    input wire [W-1:0] out,
    input wire [W-1:0] oe,
    input wire [W-1:0] pull_en,
    input wire [W-1:0] board,
    output wire [W-1:0] pin
);
    // a driven line wins, then the pull-up; a floating line shows what the board applies, never a held copy
    assign pin = (oe & out) | (~oe & pull_en) | (~oe & ~pull_en & board);
endmodule // ppo_pin_model

// file: verification/ppo_port_io_properties.sv
`timescale 1ns/1ns
module ppo_port_io_properties (
    input wire mclk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire compat_mode,
    input wire [7:0] pad_a_out,
    input wire [7:0] pad_a_oe,
    input wire [7:0] pad_a_pullup,
    input wire [7:0] pad_c_oe,
    input wire ext_ale,
    input wire ext_rd_strobe,
    input wire ext_wr_strobe,
    input wire [4:0] pad_g_out,
    input wire [4:0] pad_g_oe,
    input wire [4:0] pad_g_pullup,
    input wire [4:0] pad_g_din,
    input wire [1:0] timer_crystal_link
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // a request counts only while no answer shows, so a held strobe is not taken twice
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence ack_pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_one_pulse: assert property (req_s |=> ack_pulse_s)
        else $error("ack late or stuck");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    a_pullup_from_regs: assert property (pad_a_pullup == (pad_a_out & ~pad_a_oe))
        else $error("pull-up mismatch");
    a_crystal_released: assert property (
        timer_crystal_link[0] |-> (pad_g_oe[4:3] | pad_g_pullup[4:3] | pad_g_din[4:3]) == 2'h0)
        else $error("crystal pins not released");
    a_wr_follows: assert property (
        pad_g_oe[0] |-> pad_g_out[0] == $past(ext_wr_strobe) && pad_g_pullup[0] == 1'h0)
        else $error("write strobe pin wrong");
    a_ale_rd_follow: assert property (
        pad_g_oe[2] |-> pad_g_out[2:1] == {$past(ext_ale), $past(ext_rd_strobe)} && pad_g_oe[1])
        else $error("latch or read pin wrong");
    a_compat_port_c: assert property (compat_mode |-> pad_c_oe == 8'hff)
        else $error("port c not driving");
    a_compat_no_gpio: assert property (compat_mode |-> pad_g_din == 5'h00)
        else $error("fifth port input live");
endmodule // ppo_port_io_properties

bind ppo_port_io ppo_port_io_properties ppo_port_io_properties_inst (.mclk(mclk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .compat_mode(compat_mode),
    .pad_a_out(pad_a_out), .pad_a_oe(pad_a_oe), .pad_a_pullup(pad_a_pullup), .pad_c_oe(pad_c_oe),
    .ext_ale(ext_ale), .ext_rd_strobe(ext_rd_strobe), .ext_wr_strobe(ext_wr_strobe), .pad_g_out(pad_g_out),
    .pad_g_oe(pad_g_oe), .pad_g_pullup(pad_g_pullup), .pad_g_din(pad_g_din),
    .timer_crystal_link(timer_crystal_link));

// file: verification/ppo_port_io_tb_top.sv
`timescale 1ns/1ns
`include "ppo_port_regs.vh"
module ppo_port_io_tb_top;
    reg mclk, resetn, cyc, stb, we, compat, s_ale, s_rd, s_wr;
    reg [7:0] adr;
    reg [31:0] wdat, board, q;
    reg [4:0] board_g;
    wire [31:0] rdat, outs, oes, pus, pins;
    wire [4:0] g_out, g_oe, g_pu, g_pin, g_din;
    wire [1:0] link;
    wire [7:0] e_latch;
    wire ack;
    integer n_errors = 0;
    integer samples_checked = 0;
    integer i;
    ppo_port_io ppo_port_io_inst (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .compat_mode(compat),
        .pad_a_in(pins[7:0]), .pad_a_out(outs[7:0]), .pad_a_oe(oes[7:0]), .pad_a_pullup(pus[7:0]),
        .pad_b_in(pins[15:8]), .pad_b_out(outs[15:8]), .pad_b_oe(oes[15:8]), .pad_b_pullup(pus[15:8]),
        .pad_c_in(pins[23:16]), .pad_c_out(outs[23:16]), .pad_c_oe(oes[23:16]), .pad_c_pullup(pus[23:16]),
        .pad_d_in(pins[31:24]), .pad_d_out(outs[31:24]), .pad_d_oe(oes[31:24]), .pad_d_pullup(pus[31:24]),
        .port_e_latch(e_latch), .ext_ale(s_ale), .ext_rd_strobe(s_rd), .ext_wr_strobe(s_wr), .pad_g_in(g_pin),
        .pad_g_out(g_out), .pad_g_oe(g_oe), .pad_g_pullup(g_pu), .pad_g_din(g_din), .timer_crystal_link(link));
    ppo_pin_model #(.W(32)) ppo_pin_model_inst (.out(outs), .oe(oes), .pull_en(pus), .board(board), .pin(pins));
    ppo_pin_model #(.W(5)) ppo_pin_model_g_inst (.out(g_out), .oe(g_oe), .pull_en(g_pu), .board(board_g),
        .pin(g_pin));
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    task report_and_stop;
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // one classic cycle; ack and read data are taken at the edge that sees ack high
    task bus(input [5:0] idx, input w, input [7:0] d);
        integer k;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'h1 && k < 40);
        q = rdat;
        if (k >= 40) chk("ack", 32'h1, 32'h0);
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge mclk);
    endtask
    task rd(input [5:0] idx, input [7:0] e, input string n);
        bus(idx, 1'h0, 8'h0);
        chk(n, {24'h0, e}, q);
    endtask
    // each port: reset values, alias write, direction split, read-only pin register
    task s_regs;
        reg [5:0] l;
        reg [7:0] v;
        rd(6'h03, 8'h00, "e latch rst");
        for (i = 0; i < 4; i++) begin
            l = 6'(27 - 3 * i);
            v = 8'h5a ^ 8'(i);
            rd(l, 8'h00, "latch rst");
            rd(l - 6'h01, 8'h00, "dir rst");
            bus(l | 6'h20, 1'h1, v);
            bus(l - 6'h01, 1'h1, 8'h0f);
            bus(l - 6'h02, 1'h1, 8'h00);
            repeat (6) @(posedge mclk);
            rd(l, v, "latch");
            rd(l - 6'h01 | 6'h20, 8'h0f, "dir alias");
            rd(l - 6'h02, {4'hf, v[3:0]}, "pins");
            chk("pad out", v, outs[8*i +: 8]);
        end
        bus(6'h23, 1'h1, 8'hc3);
        rd(6'h03, 8'hc3, "e latch");
        chk("e copy", 8'hc3, e_latch);
        bus(6'h05, 1'h1, 8'hff);
        rd(6'h05, 8'h00, "unmapped");
    endtask
    // crystal and memory strobe overrides on the fifth port
    task s_fifth;
        chk("xtal din free", 2'h3, g_din[4:3]);
        bus(`PPO_IDX_CTRL, 1'h1, 8'hff);
        rd(`PPO_IDX_CTRL, 8'h03, "ctrl");
        {s_ale, s_rd, s_wr} <= 3'h5;
        repeat (3) @(posedge mclk);
        chk("link", 2'h3, link);
        chk("xtal", 6'h00, {g_oe[4:3], g_pu[4:3], g_din[4:3]});
        chk("mem lines", 9'h1c5, {g_oe[2:0], g_pu[2:0], g_out[2:0]});
        {s_ale, s_rd, s_wr} <= 3'h2;
        repeat (2) @(posedge mclk);
        chk("strobes", 3'h2, g_out[2:0]);
        bus(`PPO_IDX_CTRL, 1'h1, 8'h00);
        repeat (2) @(posedge mclk);
        chk("released", 7'h0, {link, g_oe});
    endtask
    // second reset with the legacy fuse set; reset clears port c registers, the fuse alone makes it drive
    task s_compat;
        resetn <= 1'h0;
        compat <= 1'h1;
        repeat (8) @(posedge mclk);
        chk("c drive", 16'hff00, {oes[23:16], outs[23:16]});
        resetn <= 1'h1;
        @(posedge mclk);
        rd(`PPO_IDX_CTRL, 8'h04, "ctrl compat");
        repeat (6) @(posedge mclk);
        chk("g din", 5'h0, g_din);
    endtask
    initial begin
        {resetn, cyc, stb, we, compat, s_ale, s_rd, s_wr} = 8'h0;
        {adr, wdat, board, board_g} = {8'h0, 32'h0, 32'hffffffff, 5'h1f};
        repeat (8) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        s_regs;
        s_fifth;
        s_compat;
        report_and_stop;
    end
    // the run needs well under a thousand cycles; a hang is cut after five thousand
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        report_and_stop;
    end
endmodule // ppo_port_io_tb_top
